// *** verilog/tcc_map.vh ***
// Register indices, field positions and timing constants of the capture/compare block
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// Register indices; byte address is four times the index
`define TCC_IDX_CAP1_HI 8'h20
`define TCC_IDX_CAP1_LO 8'h21
`define TCC_IDX_CMP_HI 8'h22
`define TCC_IDX_CMP_LO 8'h23
`define TCC_IDX_CAP2_HI 8'h24
`define TCC_IDX_CAP2_LO 8'h25
`define TCC_IDX_CTRL 8'h2C
`define TCC_IDX_STAT 8'h2E

// Control register fields
`define TCC_C_IRQ1 7
`define TCC_C_IRQ2 6
`define TCC_C_CIRQ 5
`define TCC_C_OUTEN 3
`define TCC_C_EDGE1 2
`define TCC_C_EDGE2 1
`define TCC_C_LEVEL 0
`define TCC_CTRL_RST 8'h00

// Status register fields
`define TCC_S_FLAG1 7
`define TCC_S_FLAG2 6
`define TCC_S_CFLAG 5
`define TCC_S_PIN1 3
`define TCC_S_PIN2 2

// Bus answers
`define TCC_RESP_OK 2'h0
`define TCC_RESP_ERR 2'h2

// Counter step: one count every four bus clocks
`define TCC_STEP_CYCLES 3'h4
`define TCC_PHASE_LAST 2'h3
`define TCC_CMP_PHASE 2'h0
`define TCC_ONE 16'h0001

`endif

// *** verilog/tcc_timer_capture_compare.v ***
// Two input capture channels and one output compare channel with AXI4-Lite access
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_map.vh"

// How it works
// - Edge on input one latches counter
// - Capture one sets flag, may request interrupt
// - Capture one read as high, low byte
// - Captured value is prior counter plus one
// - Counter advances once every four clocks
// - Capture reloads whether flag set or not
// - High byte read blocks transfer until low
// - Low byte read never blocks transfer
// - Reset leaves capture contents unchanged
// - Input two latches, flags, may interrupt
// - Capture two bytes with same interlock
// - Compare register matched to counter, sets flag
// - Match drives level pin when enabled
// - Match requests interrupt when enabled
// - High compare write suspends matching
// - Low compare write alone never suspends
// - Compare bytes written independently
// - Level latched on every match while output enabled
// - Compare register untouched by reset, hardware
// - Edge bit one rising, zero falling
// - Flag clears on status then low read
// - Level bit one drives high, zero low
module tcc_timer_capture_compare #(
   parameter AW = 12, // Address width
   parameter CW = 16 // Counter width
) (
   input wire clk,
   input wire nrst,
   input wire [CW-1:0] timerCount,
   input wire captureInOne,
   input wire captureInTwo,
   output reg countStep,
   output reg compareOutPin,
   output reg timerIrq,
   output reg captureEventOne,
   output reg captureEventTwo,
   output reg compareEvent,
   input wire [AW-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [AW-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   // ==========================================================
   // Helpers
   // ==========================================================
   // Register index from a byte address
   function [7:0] regIndex;
      input [AW-1:0] addr;
      begin
         regIndex = addr[9:2];
      end
   endfunction

   // Upper or lower byte of a 16-bit value
   function [7:0] pickByte;
      input [CW-1:0] value;
      input upper;
      begin
         pickByte = upper ? value[CW-1:8] : value[7:0];
      end
   endfunction

   // Register index holds a mapped register
   function isMapped;
      input [7:0] idx;
      begin
         isMapped = (idx >= `TCC_IDX_CAP1_HI && idx <= `TCC_IDX_CAP2_LO)
            || idx == `TCC_IDX_CTRL || idx == `TCC_IDX_STAT;
      end
   endfunction

   // ==========================================================
   // Reset release
   // ==========================================================
   reg rstMeta; // First release stage
   reg rstN; // Released reset used everywhere

   // Assert at once, release after two edges
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN <= rstMeta;
      end
   end

   // ==========================================================
   // Declarations
   // ==========================================================
   reg [AW-1:0] wrAddr; // Held write address
   reg [7:0] wrByte; // Held write data, low lane
   reg wrLane; // Low byte lane enabled
   reg [7:0] timerControl; // Control bits
   reg captureFlagOne, captureFlagTwo, compareFlag; // Status flags
   reg armOne, armTwo, armCmp; // Status read seen, per flag
   reg lockOne, lockTwo; // Capture transfer blocked
   reg cmpHold; // Compare suspended
   reg [1:0] phase; // Position within a counter step
   reg [2:0] syncOne, syncTwo; // Two sync stages, then history
   reg [CW-1:0] countD1, countD2; // Counter delayed to match sync
   reg [CW-1:0] captureRegOne, captureRegTwo; // Capture values
   reg [CW-1:0] compareRegOne; // Compare value
   reg [7:0] readByte; // Byte selected for a read
   reg readOk; // Read index is mapped
   wire doWrite; // Address and data both held
   wire doRead; // Read address taken this edge
   wire [7:0] wIdx, rIdx; // Write and read register index
   wire riseOne, fallOne, riseTwo, fallTwo; // Synchronised pin edges
   wire hitOne, hitTwo; // Valid transition per channel
   wire rdHiOne, rdLoOne, rdHiTwo, rdLoTwo; // Capture byte reads
   wire rdStat; // Read of status
   wire wrCmpHi, wrCmpLo; // Compare byte writes
   wire cmpLoAccess; // Any access to compare lower byte
   wire match; // Compare match this clock
   wire [7:0] statusByte; // Status as read

   assign doWrite = !s_axi_awready && !s_axi_wready
      && !s_axi_bvalid;
   assign doRead = s_axi_arvalid && s_axi_arready;
   assign wIdx = regIndex(wrAddr);
   assign rIdx = regIndex(s_axi_araddr);

   // ==========================================================
   // Register decode and side effects
   // ==========================================================
   assign rdHiOne = doRead && (rIdx == `TCC_IDX_CAP1_HI);
   assign rdLoOne = doRead && (rIdx == `TCC_IDX_CAP1_LO);
   assign rdHiTwo = doRead && (rIdx == `TCC_IDX_CAP2_HI);
   assign rdLoTwo = doRead && (rIdx == `TCC_IDX_CAP2_LO);
   assign rdStat = doRead && (rIdx == `TCC_IDX_STAT);
   assign wrCmpHi = doWrite && wrLane
      && (wIdx == `TCC_IDX_CMP_HI);
   assign wrCmpLo = doWrite && wrLane
      && (wIdx == `TCC_IDX_CMP_LO);
   assign cmpLoAccess = wrCmpLo
      || (doRead && (rIdx == `TCC_IDX_CMP_LO));

   assign statusByte = {captureFlagOne, captureFlagTwo,
      compareFlag, 1'b0, syncOne[1], syncTwo[1], 2'b00};

   // ==========================================================
   // Write channel
   // ==========================================================
   // Address and data taken in either order, answered together
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TCC_RESP_OK;
         wrAddr <= {AW{1'b0}};
         wrByte <= 8'h00;
         wrLane <= 1'b0;
         timerControl <= `TCC_CTRL_RST;
      end else begin
         // Hold the address once taken
         if (s_axi_awvalid && s_axi_awready) begin
            wrAddr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         // Hold the low data byte once taken
         if (s_axi_wvalid && s_axi_wready) begin
            wrByte <= s_axi_wdata[7:0];
            wrLane <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         // Both present: store and answer
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            // Read-only words take the write silently
            s_axi_bresp <= isMapped(wIdx) ? `TCC_RESP_OK : `TCC_RESP_ERR;
            if (wrLane && (wIdx == `TCC_IDX_CTRL)) begin
               timerControl <= wrByte;
            end
         end
         // Response taken: open for the next write
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Compare bytes, no reset and no hardware update
   always @(posedge clk) begin
      if (wrCmpHi) begin
         compareRegOne[CW-1:8] <= wrByte;
      end
      if (wrCmpLo) begin
         compareRegOne[7:0] <= wrByte;
      end
   end

   // ==========================================================
   // Read channel
   // ==========================================================
   // Byte shown for the read index; unmapped reads as zero
   always @* begin
      readOk = isMapped(rIdx);
      case (rIdx)
         `TCC_IDX_CAP1_HI: readByte = pickByte(captureRegOne, 1'b1);
         `TCC_IDX_CAP1_LO: readByte = pickByte(captureRegOne, 1'b0);
         `TCC_IDX_CMP_HI: readByte = pickByte(compareRegOne, 1'b1);
         `TCC_IDX_CMP_LO: readByte = pickByte(compareRegOne, 1'b0);
         `TCC_IDX_CAP2_HI: readByte = pickByte(captureRegTwo, 1'b1);
         `TCC_IDX_CAP2_LO: readByte = pickByte(captureRegTwo, 1'b0);
         `TCC_IDX_CTRL: readByte = timerControl;
         `TCC_IDX_STAT: readByte = statusByte;
         default: readByte = 8'h00;
      endcase
   end

   // One read at a time, answered the clock after it is taken
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TCC_RESP_OK;
      end else begin
         if (doRead) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= readOk ? `TCC_RESP_OK : `TCC_RESP_ERR;
            s_axi_rdata <= {24'h000000, readByte};
         end
         // Answer taken: ready for the next read
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Counter step and input synchronisers
   // ==========================================================
   // Step pulse for the counter once every four clocks
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         phase <= 2'h0;
         countStep <= 1'b0;
      end else begin
         phase <= phase + 2'h1;
         countStep <= (phase == `TCC_PHASE_LAST);
      end
   end

   // Two sync stages, then one stage of history
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         syncOne <= 3'h0;
         syncTwo <= 3'h0;
      end else begin
         syncOne <= {syncOne[1:0], captureInOne};
         syncTwo <= {syncTwo[1:0], captureInTwo};
      end
   end

   // Counter delayed to line up with the sync stages
   always @(posedge clk) begin
      countD1 <= timerCount;
      countD2 <= countD1;
   end

   assign riseOne = syncOne[1] && !syncOne[2];
   assign fallOne = !syncOne[1] && syncOne[2];
   assign riseTwo = syncTwo[1] && !syncTwo[2];
   assign fallTwo = !syncTwo[1] && syncTwo[2];
   assign hitOne = timerControl[`TCC_C_EDGE1]
      ? riseOne : fallOne;
   assign hitTwo = timerControl[`TCC_C_EDGE2]
      ? riseTwo : fallTwo;

   // ==========================================================
   // Capture registers
   // ==========================================================
   // No reset: contents survive it; low read never blocks
   always @(posedge clk) begin
      if (hitOne && (!lockOne || rdLoOne)) begin
         captureRegOne <= countD2 + `TCC_ONE;
      end
      if (hitTwo && (!lockTwo || rdLoTwo)) begin
         captureRegTwo <= countD2 + `TCC_ONE;
      end
   end

   // Upper-byte read locks, lower-byte read unlocks
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         lockOne <= 1'b0;
         lockTwo <= 1'b0;
      end else begin
         lockOne <= rdHiOne || (lockOne && !rdLoOne);
         lockTwo <= rdHiTwo || (lockTwo && !rdLoTwo);
      end
   end

   // ==========================================================
   // Compare
   // ==========================================================
   assign match = !cmpHold && (phase == `TCC_CMP_PHASE)
      && (compareRegOne == timerCount);

   // Upper write suspends, lower write resumes
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         cmpHold <= 1'b0;
      end else if (wrCmpHi) begin
         cmpHold <= 1'b1;
      end else if (wrCmpLo) begin
         cmpHold <= 1'b0;
      end
   end

   // Level bit latched to the pin on each enabled match
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         compareOutPin <= 1'b0;
      end else if (match && timerControl[`TCC_C_OUTEN]) begin
         compareOutPin <= timerControl[`TCC_C_LEVEL];
      end
   end

   // ==========================================================
   // Flags, events and interrupt request
   // ==========================================================
   // Status read arms; lower access clears; set wins
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         captureFlagOne <= 1'b0;
         captureFlagTwo <= 1'b0;
         compareFlag <= 1'b0;
         armOne <= 1'b0;
         armTwo <= 1'b0;
         armCmp <= 1'b0;
      end else begin
         captureFlagOne <= hitOne
            || (captureFlagOne && !(armOne && rdLoOne));
         captureFlagTwo <= hitTwo
            || (captureFlagTwo && !(armTwo && rdLoTwo));
         compareFlag <= match
            || (compareFlag && !(armCmp && cmpLoAccess));
         armOne <= rdStat || (armOne && !rdLoOne);
         armTwo <= rdStat || (armTwo && !rdLoTwo);
         armCmp <= rdStat || (armCmp && !cmpLoAccess);
      end
   end

   // Registered event pulses and combined request
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         captureEventOne <= 1'b0;
         captureEventTwo <= 1'b0;
         compareEvent <= 1'b0;
         timerIrq <= 1'b0;
      end else begin
         captureEventOne <= hitOne;
         captureEventTwo <= hitTwo;
         compareEvent <= match;
         timerIrq <=
            (captureFlagOne && timerControl[`TCC_C_IRQ1])
            || (captureFlagTwo && timerControl[`TCC_C_IRQ2])
            || (compareFlag && timerControl[`TCC_C_CIRQ]);
      end
   end

endmodule // tcc_timer_capture_compare

`default_nettype wire

// *** testbench/tcc_cc_assertions.sv ***
// Port checker for the capture/compare block, bound to its top module
`timescale 1ns/1ns
`default_nettype none
`include "tcc_map.vh"
module tcc_cc_checker #(
   parameter AW = 12,
   parameter CW = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [CW-1:0] timerCount,
   input wire logic captureInOne,
   input wire logic captureInTwo,
   input wire logic countStep,
   input wire logic compareOutPin,
   input wire logic timerIrq,
   input wire logic captureEventOne,
   input wire logic captureEventTwo,
   input wire logic compareEvent,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ==========================================================
   // Shared clocking
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // ==========================================================
   // Bus steps
   // Address and data taken at one edge
   sequence wrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Read of an unmapped word taken
   sequence badRead;
      s_axi_arvalid && s_axi_arready && (s_axi_araddr == 12'h000);
   endsequence

   // ==========================================================
   // Timer events
   step_period_a: assert property (countStep |=> !countStep [*3] ##1 countStep)
      else $error("count step not every four clocks");
   cap_one_pulse_a: assert property (captureEventOne |=> !captureEventOne)
      else $error("capture one event longer than a cycle");
   cap_two_pulse_a: assert property (captureEventTwo |=> !captureEventTwo)
      else $error("capture two event longer than a cycle");
   cmp_spacing_a: assert property (compareEvent |=> !compareEvent [*3])
      else $error("compare events closer than one count");
   pin_on_match_a: assert property ($changed(compareOutPin) |-> compareEvent)
      else $error("compare pin moved without a match");

   // ==========================================================
   // Register bus
   write_answer_a: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   write_hold_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channels ready while response pending");
   unmapped_read_a: assert property (badRead |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == `TCC_RESP_ERR))
      else $error("unmapped read not refused");
   read_hold_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address ready while data pending");
   upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
endmodule // tcc_cc_checker

bind tcc_timer_capture_compare tcc_cc_checker #(.AW(AW), .CW(CW)) chk (
   .clk(clk), .nrst(nrst), .timerCount(timerCount),
   .captureInOne(captureInOne), .captureInTwo(captureInTwo),
   .countStep(countStep), .compareOutPin(compareOutPin),
   .timerIrq(timerIrq), .captureEventOne(captureEventOne),
   .captureEventTwo(captureEventTwo), .compareEvent(compareEvent),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// *** testbench/tcc_count_model.sv ***
// Free-running counter that stands beside the capture/compare block
`timescale 1ns/1ns
`default_nettype none
module tcc_count_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic countStep,
   output logic [15:0] timerCount
);
   // ==========================================================
   // Counter: restarts near the top so a wrap is crossed early
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timerCount <= 16'hFFFC;
      end else if (countStep) begin
         timerCount <= timerCount + 16'h0001;
      end
   end
endmodule // tcc_count_model
`default_nettype wire

// *** testbench/tcc_timer_capture_compare_test.sv ***
// Self-checking bench for the capture/compare block
`timescale 1ns/1ns
`default_nettype none
`include "tcc_map.vh"
module tcc_timer_capture_compare_test;
   // ==========================================================
   // Signals
   logic clk, nrst, captureInOne, captureInTwo;
   logic [15:0] timerCount;
   logic countStep, compareOutPin, timerIrq, compareEvent;
   logic captureEventOne, captureEventTwo;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   int error_cnt, cmp_count, cycles;
   logic [15:0] capTwoVal; // Last value caught on channel two

   tcc_timer_capture_compare dut (.clk(clk), .nrst(nrst),
      .timerCount(timerCount), .captureInOne(captureInOne),
      .captureInTwo(captureInTwo), .countStep(countStep),
      .compareOutPin(compareOutPin), .timerIrq(timerIrq),
      .captureEventOne(captureEventOne),
      .captureEventTwo(captureEventTwo), .compareEvent(compareEvent),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   tcc_count_model cnt (.clk(clk), .nrst(nrst), .countStep(countStep),
      .timerCount(timerCount));

   // ==========================================================
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   // ==========================================================
   // Helpers
   task automatic report_and_stop();
      $display("Mismatches %0d, comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Bus write of one byte; address and data offered together
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk);
      s_axi_awaddr <= {2'h0, idx, 2'h0};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   // Bus read; data and answer taken at the handshake edge
   task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= {2'h0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(idx, d, r);
      chk(d, {24'h000000, e});
   endtask
   // Looks for an event pulse over n cycles
   task automatic wait_ev(input int k, input int n, output logic hit);
      hit = 1'b0;
      repeat (n) begin
         @(posedge clk);
         if ((k == 1 && captureEventOne) || (k == 2 && captureEventTwo)
             || (k == 3 && compareEvent)) hit = 1'b1;
      end
   endtask
   // Pin change just after a counter step so the count is steady
   task automatic cap(input int k, input logic lvl, output logic [15:0] e);
      logic hit;
      do @(posedge clk); while (!countStep);
      @(posedge clk);
      e = timerCount + 16'h0001;
      if (k == 1) captureInOne <= lvl;
      else captureInTwo <= lvl;
      wait_ev(k, 10, hit);
      chk(32'(hit), 32'h1);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_bus();
      logic [31:0] d;
      logic [1:0] r;
      wr(`TCC_IDX_CMP_HI, 8'hA5);
      wr(`TCC_IDX_CMP_LO, 8'h3C);
      rchk(`TCC_IDX_CMP_HI, 8'hA5);
      wr(`TCC_IDX_CMP_LO, 8'h5A);
      rchk(`TCC_IDX_CMP_HI, 8'hA5);
      rchk(`TCC_IDX_CMP_LO, 8'h5A);
      rd(8'h00, d, r);
      chk(32'(r), 32'(`TCC_RESP_ERR));
   endtask
   task automatic t_cap_one();
      logic [15:0] e;
      logic [31:0] d;
      logic [1:0] r;
      logic hit;
      wr(`TCC_IDX_CTRL, 8'h84);
      captureInOne <= 1'b0;
      wait_ev(1, 8, hit);
      chk(32'(hit), 32'h0);
      cap(1, 1'b1, e);
      rd(`TCC_IDX_STAT, d, r);
      chk(32'(d[7]), 32'h1);
      chk(32'(timerIrq), 32'h1);
      rchk(`TCC_IDX_CAP1_HI, e[15:8]);
      rchk(`TCC_IDX_CAP1_LO, e[7:0]);
      rd(`TCC_IDX_STAT, d, r);
      chk(32'(d[7]), 32'h0);
      chk(32'(timerIrq), 32'h0);
   endtask
   task automatic t_lock();
      logic [15:0] e1, e2;
      wr(`TCC_IDX_CTRL, 8'h00);
      cap(1, 1'b0, e1);
      rchk(`TCC_IDX_CAP1_HI, e1[15:8]);
      captureInOne <= 1'b1;
      repeat (6) @(posedge clk);
      cap(1, 1'b0, e2);
      rchk(`TCC_IDX_CAP1_LO, e1[7:0]);
      captureInOne <= 1'b1;
      repeat (6) @(posedge clk);
      cap(1, 1'b0, e2);
      rchk(`TCC_IDX_CAP1_HI, e2[15:8]);
      rchk(`TCC_IDX_CAP1_LO, e2[7:0]);
   endtask
   task automatic t_cap_two();
      logic [31:0] d;
      logic [1:0] r;
      wr(`TCC_IDX_CTRL, 8'h42);
      cap(2, 1'b1, capTwoVal);
      rd(`TCC_IDX_STAT, d, r);
      chk(32'(d[6]), 32'h1);
      chk(32'(timerIrq), 32'h1);
      rchk(`TCC_IDX_CAP2_HI, capTwoVal[15:8]);
      rchk(`TCC_IDX_CAP2_LO, capTwoVal[7:0]);
   endtask
   task automatic t_cmp();
      logic [15:0] t;
      logic [31:0] d;
      logic [1:0] r;
      logic hit;
      wr(`TCC_IDX_CTRL, 8'h29);
      t = timerCount + 16'h0006;
      wr(`TCC_IDX_CMP_HI, t[15:8]);
      rd(`TCC_IDX_STAT, d, r);
      wr(`TCC_IDX_CMP_LO, t[7:0]);
      wait_ev(3, 40, hit);
      chk(32'(hit), 32'h1);
      chk(32'(compareOutPin), 32'h1);
      chk(32'(timerIrq), 32'h1);
      rd(`TCC_IDX_STAT, d, r);
      chk(32'(d[5]), 32'h1);
      wr(`TCC_IDX_CTRL, 8'h28);
      t = timerCount + 16'h0006;
      wr(`TCC_IDX_CMP_HI, t[15:8]);
      wr(`TCC_IDX_CMP_LO, t[7:0]);
      wait_ev(3, 40, hit);
      chk(32'(compareOutPin), 32'h0);
      t = timerCount + 16'h0010;
      wr(`TCC_IDX_CMP_HI, t[15:8]);
      wait_ev(3, 30, hit);
      chk(32'(hit), 32'h0);
      wr(`TCC_IDX_CMP_LO, t[7:0]);
      wait_ev(3, 60, hit);
      chk(32'(hit), 32'h1);
      while (timerCount[7:0] > 8'hC0) @(posedge clk);
      t = timerCount + 16'h0008;
      wr(`TCC_IDX_CMP_HI, t[15:8]);
      wr(`TCC_IDX_CMP_LO, 8'hFF);
      wr(`TCC_IDX_CMP_LO, t[7:0]);
      wait_ev(3, 60, hit);
      chk(32'(hit), 32'h1);
   endtask
   // Second reset in mid-run must keep stored values
   task automatic t_reset();
      wr(`TCC_IDX_CMP_HI, 8'h12);
      wr(`TCC_IDX_CMP_LO, 8'h34);
      nrst <= 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      repeat (5) @(posedge clk);
      rchk(`TCC_IDX_CMP_HI, 8'h12);
      rchk(`TCC_IDX_CMP_LO, 8'h34);
      rchk(`TCC_IDX_CAP2_HI, capTwoVal[15:8]);
      rchk(`TCC_IDX_CAP2_LO, capTwoVal[7:0]);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      nrst = 1'b0;
      captureInOne = 1'b1;
      captureInTwo = 1'b0;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hF;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      error_cnt = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (5) @(posedge clk);
      t_bus();
      t_cap_one();
      t_lock();
      t_cap_two();
      t_cmp();
      t_reset();
      report_and_stop();
   end
endmodule // tcc_timer_capture_compare_test
`default_nettype wire
